// File: logic/tcc_timer.sv
/*
 * Timer capture and compare unit: 16-bit free-running counter behind a
 * divide-by-four prescaler, input capture, output compare, control and
 * flag registers with two-step flag clears. Assumes an Avalon-MM master
 * that holds its request until waitrequest is seen low, and a capture
 * pin synchronous to CLK_I.
 */
// Register access over Avalon-MM is decoded here, answering each request after one wait cycle.
`timescale 1ns/1ps
module tcc_timer (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RESETN_I,
   // register bus
   input wire tcc_pkg::tcc_bus_req_s BUS_I,
   output logic [31:0] READDATA_O,
   output logic WAITREQUEST_O,
   // pins
   input wire logic CAPTURE_INPUT_PIN_I,
   output logic COMPARE_OUTPUT_PIN_O,
   output logic IRQ_O
);
   import tcc_pkg::*;

   // ==========================================================
   // bus decode
   logic wait_q;
   logic acc_rd;
   logic acc_wr;
   logic [5:0] idx;
   assign idx = BUS_I.address[7:2];
   assign acc_rd = BUS_I.read && wait_q;
   assign acc_wr = BUS_I.write && wait_q;

   function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
      hit = (a == r);
   endfunction : hit

   logic rd_cap_hi, rd_cap_lo, wr_cmp_hi, wr_cmp_lo, acc_cmp_lo;
   logic acc_flags, rd_cnt_lo, wr_any_cnt_lo;
   assign rd_cap_hi = acc_rd && hit(idx, IDX_CAP_HI);
   assign rd_cap_lo = acc_rd && hit(idx, IDX_CAP_LO);
   assign wr_cmp_hi = acc_wr && hit(idx, IDX_CMP_HI);
   assign wr_cmp_lo = acc_wr && hit(idx, IDX_CMP_LO);
   assign acc_cmp_lo = (acc_rd || acc_wr) && hit(idx, IDX_CMP_LO);
   assign acc_flags = (acc_rd || acc_wr) && hit(idx, IDX_FLAGS);
   assign rd_cnt_lo = acc_rd && hit(idx, IDX_CNT_LO);
   assign wr_any_cnt_lo = acc_wr &&
      (hit(idx, IDX_CNT_LO) || hit(idx, IDX_ALT_LO));

   // ==========================================================
   // state
   logic [7:0] control_q;
   logic [7:0] flags_q;
   logic [1:0] presc_q;
   logic [15:0] count_q;
   logic [15:0] compare_q;
   logic [15:0] capture_q;
   logic cmp_hold_q;
   logic cap_hold_q;
   logic out_level_q;
   logic irq_q;
   logic [7:0] readdata_q;

   // ==========================================================
   // prescaler and counter
   logic tick;
   assign tick = (presc_q == PRESCALE_LAST);

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         presc_q <= '0;
         count_q <= COUNTER_RESET;
      end else if (wr_any_cnt_lo) begin
         presc_q <= '0;
         count_q <= COUNTER_RESET;
      end else begin
         presc_q <= presc_q + 2'h1;
         if (tick) begin
            count_q <= count_q + 16'h1;
         end
      end
   end

   // ==========================================================
   // control register
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         control_q <= CONTROL_RESET;
      end else if (acc_wr && hit(idx, IDX_CONTROL)) begin
         control_q <= BUS_I.writedata[7:0] & CONTROL_MASK;
      end
   end

   // ==========================================================
   // compare value: no reset, byte-wise writes
   always_ff @(posedge CLK_I) begin
      if (wr_cmp_hi) begin
         compare_q[15:8] <= BUS_I.writedata[7:0];
      end
      if (wr_cmp_lo) begin
         compare_q[7:0] <= BUS_I.writedata[7:0];
      end
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         cmp_hold_q <= 1'b0;
      end else if (wr_cmp_lo) begin
         cmp_hold_q <= 1'b0;
      end else if (wr_cmp_hi) begin
         cmp_hold_q <= 1'b1;
      end
   end

   // compared once per count, first clock after the step
   logic match;
   assign match = (presc_q == 2'h0) && !cmp_hold_q &&
      (count_q == compare_q);

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         out_level_q <= 1'b0;
      end else if (match) begin
         out_level_q <= control_q[BIT_OUT_LEVEL];
      end
   end

   // ==========================================================
   // capture path
   logic pin_s1_q, pin_s2_q, pin_s3_q;
   logic [15:0] count_d1_q, count_d2_q;
   logic edge_hit;
   logic cap_take;

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         pin_s3_q <= 1'b0;
      end else begin
         pin_s1_q <= CAPTURE_INPUT_PIN_I;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // counter history lined up with the synchroniser
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         count_d1_q <= COUNTER_RESET;
         count_d2_q <= COUNTER_RESET;
      end else begin
         count_d1_q <= count_q;
         count_d2_q <= count_d1_q;
      end
   end

   assign edge_hit = control_q[BIT_EDGE_SEL] ?
      (pin_s2_q && !pin_s3_q) : (!pin_s2_q && pin_s3_q);
   // a low read in the same cycle releases the block
   assign cap_take = edge_hit && (!cap_hold_q || rd_cap_lo);

   always_ff @(posedge CLK_I) begin
      if (cap_take) begin
         capture_q <= count_d2_q + 16'h1;
      end
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         cap_hold_q <= 1'b0;
      end else if (rd_cap_lo) begin
         cap_hold_q <= 1'b0;
      end else if (rd_cap_hi) begin
         cap_hold_q <= 1'b1;
      end
   end

   // ==========================================================
   // flags with armed two-step clear; set wins over clear
   logic [2:0] fl_set, fl_fin;
   logic [2:0] arm_q;
   localparam int FL_POS [3] = '{BIT_CAPTURE, BIT_COMPARE, BIT_OVERFLOW};
   assign fl_set = {edge_hit, match, tick && (count_q == COUNTER_TOP)};
   assign fl_fin = {rd_cap_lo, acc_cmp_lo, rd_cnt_lo};

   generate
      for (genvar g = 0; g < 3; g++) begin : g_flag
         localparam int P = FL_POS[2 - g];
         always_ff @(posedge CLK_I or negedge RESETN_I) begin
            if (!RESETN_I) begin
               flags_q[P] <= 1'b0;
               arm_q[g] <= 1'b0;
            end else if (fl_set[g]) begin
               flags_q[P] <= 1'b1;
            end else if (arm_q[g] && fl_fin[g]) begin
               flags_q[P] <= 1'b0;
               arm_q[g] <= 1'b0;
            end else if (acc_flags && flags_q[P]) begin
               arm_q[g] <= 1'b1;
            end else if (!flags_q[P]) begin
               arm_q[g] <= 1'b0;
            end
         end
      end
   endgenerate
   assign flags_q[4:0] = '0;

   // ==========================================================
   // interrupt
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(flags_q & control_q & 8'he0);
      end
   end

   // ==========================================================
   // read mux and waitrequest
   logic [7:0] rd_mux;
   always_comb begin
      unique case (idx)
         IDX_CONTROL: rd_mux = control_q;
         IDX_FLAGS: rd_mux = flags_q;
         IDX_CAP_HI: rd_mux = capture_q[15:8];
         IDX_CAP_LO: rd_mux = capture_q[7:0];
         IDX_CMP_HI: rd_mux = compare_q[15:8];
         IDX_CMP_LO: rd_mux = compare_q[7:0];
         IDX_CNT_HI, IDX_ALT_HI: rd_mux = count_q[15:8];
         IDX_CNT_LO, IDX_ALT_LO: rd_mux = count_q[7:0];
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         wait_q <= 1'b1;
         readdata_q <= 8'h00;
      end else begin
         wait_q <= !(acc_rd || acc_wr);
         if (acc_rd) begin
            readdata_q <= rd_mux;
         end
      end
   end

   assign READDATA_O = {24'h000000, readdata_q};
   assign WAITREQUEST_O = wait_q;
   assign COMPARE_OUTPUT_PIN_O = out_level_q;
   assign IRQ_O = irq_q;

   // ==========================================================
   // assertions
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);

   sequence s_status_armed(int b);
      acc_flags && flags_q[b];
   endsequence

   counter_step_a: assert property (
      tick |=> count_q == $past(count_q) + 16'h1 || $past(wr_any_cnt_lo))
      else $error("counter did not step after prescaler");
   counter_hold_a: assert property (
      !tick && !wr_any_cnt_lo |=> $stable(count_q))
      else $error("counter moved between prescaler ticks");
   compare_flag_a: assert property (
      match |=> flags_q[BIT_COMPARE])
      else $error("match did not set compare flag");
   compare_hold_a: assert property (
      wr_cmp_hi && !wr_cmp_lo |=> !match until wr_cmp_lo)
      else $error("compare matched while held off");
   out_level_a: assert property (
      match |=> out_level_q == $past(control_q[BIT_OUT_LEVEL]))
      else $error("output pin missed level on match");
   capture_value_a: assert property (
      cap_take |=> capture_q == $past(count_d2_q) + 16'h1)
      else $error("capture value wrong");
   capture_block_a: assert property (
      cap_hold_q && !rd_cap_lo |=> $stable(capture_q))
      else $error("capture changed while blocked");
   capture_clear_a: assert property (
      s_status_armed(BIT_CAPTURE) && !edge_hit ##1
      (rd_cap_lo && !edge_hit)[*1] |=> !flags_q[BIT_CAPTURE])
      else $error("capture flag not cleared by sequence");
   overflow_keep_a: assert property (
      acc_rd && hit(idx, IDX_ALT_LO) && flags_q[BIT_OVERFLOW]
      |=> flags_q[BIT_OVERFLOW])
      else $error("alternate read cleared overflow flag");
   capture_flag_a: assert property (
      edge_hit |=> flags_q[BIT_CAPTURE])
      else $error("valid edge did not set capture flag");
   overflow_flag_a: assert property (
      tick && count_q == COUNTER_TOP |=> flags_q[BIT_OVERFLOW])
      else $error("counter wrap did not set overflow flag");
   irq_follow_a: assert property (
      ##1 irq_q == |($past(flags_q) & $past(control_q) & 8'he0))
      else $error("interrupt does not follow flags and enables");
   bus_answer_a: assert property (
      (BUS_I.read || BUS_I.write) && wait_q |=> !wait_q ##1 wait_q)
      else $error("waitrequest answer not one cycle");
endmodule : tcc_timer

// File: shared/tcc_pkg.sv
/*
 * Constants, register map and bus carrier types for the timer capture and
 * compare unit. Assumes an Avalon-MM master with byte addresses and
 * 32-bit data; each 8-bit register sits in the low byte of one word.
 */
package tcc_pkg;
   // ==========================================================
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_CONTROL = 6'h12;
   localparam logic [5:0] IDX_FLAGS = 6'h13;
   localparam logic [5:0] IDX_CAP_HI = 6'h14;
   localparam logic [5:0] IDX_CAP_LO = 6'h15;
   localparam logic [5:0] IDX_CMP_HI = 6'h16;
   localparam logic [5:0] IDX_CMP_LO = 6'h17;
   localparam logic [5:0] IDX_CNT_HI = 6'h18;
   localparam logic [5:0] IDX_CNT_LO = 6'h19;
   localparam logic [5:0] IDX_ALT_HI = 6'h1a;
   localparam logic [5:0] IDX_ALT_LO = 6'h1b;
   // ==========================================================
   // field positions; the three flag bits are shared with their enables
   localparam int BIT_CAPTURE = 7;
   localparam int BIT_COMPARE = 6;
   localparam int BIT_OVERFLOW = 5;
   localparam int BIT_EDGE_SEL = 1;
   localparam int BIT_OUT_LEVEL = 0;
   localparam logic [7:0] CONTROL_MASK = 8'he3;
   // ==========================================================
   // reset values and timing
   localparam logic [7:0] CONTROL_RESET = 8'h01;
   localparam logic [15:0] COUNTER_RESET = 16'hfffc;
   localparam logic [15:0] COUNTER_TOP = 16'hffff;
   localparam logic [1:0] PRESCALE_LAST = 2'h3;
   // ==========================================================
   // bus request carrier
   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
   } tcc_bus_req_s;
endpackage : tcc_pkg

// File: test/tb_timer_capture_compare_unit.sv
/*
 * Self-checking bench for the timer capture and compare unit.
 * Assumes tcc_pkg, tcc_timer and tcc_pin_model are compiled first.
 */
`timescale 1ns/1ps
module tb_timer_capture_compare_unit;
   import tcc_pkg::*;
   logic clk;
   logic rst_n;
   tcc_bus_req_s bus;
   logic [31:0] rdata;
   logic waitreq;
   logic pin;
   logic pin_lvl;
   logic cmp_pin;
   logic irq;
   int err_total;
   int cmp_count;
   int cycles;
   logic [15:0] exp_q[$];
   logic [15:0] note;
   logic [31:0] lfsr_q;
   logic [7:0] hi_v;
   logic [7:0] lo_v;

   tcc_timer uut (
      .CLK_I(clk), .RESETN_I(rst_n), .BUS_I(bus),
      .READDATA_O(rdata), .WAITREQUEST_O(waitreq),
      .CAPTURE_INPUT_PIN_I(pin), .COMPARE_OUTPUT_PIN_O(cmp_pin),
      .IRQ_O(irq));
   tcc_pin_model pins (.clk_i(clk), .level_i(pin_lvl), .pin_o(pin));

   // ======================================================
   // helpers
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task automatic chk(input string what, input logic [7:0] e,
                      input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict

   // one bus access; a read notes its expectation with a bit mask
   task automatic acc(input logic wr, input logic [5:0] idx,
                      input logic [7:0] d, input logic [7:0] m);
      int n;
      if (!wr) exp_q.push_back({m, d});
      @(posedge clk);
      bus <= '{read: !wr, write: wr, address: {idx, 2'h0},
               writedata: {24'h0, d}};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 20);
      if (n >= 20) chk("bus answer", 8'h00, 8'h01);
      bus <= '0;
   endtask : acc

   // ======================================================
   // clock, timeout and read monitor
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_total++;
         print_verdict();
      end
   end

   always @(posedge clk) begin
      if (waitreq === 1'b0 && bus.read === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk("read note", 8'h00, 8'h01);
         end else begin
            note = exp_q.pop_front();
            chk("read data", note[7:0] & note[15:8],
                rdata[7:0] & note[15:8]);
         end
      end
   end

   // ======================================================
   // main sequence
   initial begin
      bus = '0;
      rst_n = 1'b0;
      pin_lvl = 1'b0;
      err_total = 0;
      cmp_count = 0;
      cycles = 0;
      lfsr_q = 32'd92641;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      acc(0, IDX_CONTROL, CONTROL_RESET, 8'he3);
      acc(0, IDX_CNT_HI, 8'hff, 8'hff);
      acc(0, IDX_FLAGS, 8'h00, 8'he0);
      repeat (12) @(posedge clk);
      acc(0, IDX_FLAGS, 8'h20, 8'h20);
      acc(0, IDX_ALT_LO, 8'h00, 8'h00);
      acc(0, IDX_FLAGS, 8'h20, 8'h20);
      acc(0, IDX_CNT_LO, 8'h00, 8'h00);
      acc(0, IDX_FLAGS, 8'h00, 8'h20);
      // compare: held off after a high write, then released
      acc(1, IDX_CONTROL, 8'h41, 8'h00);
      acc(1, IDX_CMP_HI, 8'h12, 8'h00);
      acc(1, IDX_CMP_LO, 8'h04, 8'h00);
      acc(1, IDX_CMP_HI, 8'h00, 8'h00);
      acc(1, IDX_CNT_LO, 8'h00, 8'h00);
      repeat (60) @(posedge clk);
      acc(0, IDX_FLAGS, 8'h00, 8'h40);
      acc(1, IDX_CMP_LO, 8'h40, 8'h00);
      repeat (260) @(posedge clk);
      acc(0, IDX_FLAGS, 8'h40, 8'h40);
      chk("compare pin", 8'h01, {7'h0, cmp_pin});
      chk("irq", 8'h01, {7'h0, irq});
      acc(1, IDX_CMP_LO, 8'h40, 8'h00);
      acc(0, IDX_FLAGS, 8'h00, 8'h40);
      chk("irq", 8'h00, {7'h0, irq});
      // byte-wise storage with random values
      lo_v = 8'h40;
      for (int i = 0; i < 3; i++) begin
         lfsr_q = lfsr_next(lfsr_q);
         hi_v = lfsr_q[7:0];
         acc(1, IDX_CMP_HI, hi_v, 8'h00);
         acc(0, IDX_CMP_HI, hi_v, 8'hff);
         acc(0, IDX_CMP_LO, lo_v, 8'hff);
         lo_v = lfsr_q[15:8];
         acc(1, IDX_CMP_LO, lo_v, 8'h00);
         acc(0, IDX_CMP_HI, hi_v, 8'hff);
      end
      // capture on rising, ignored falling, then falling selected
      acc(1, IDX_CONTROL, 8'h82, 8'h00);
      // counter restarts at fffc so the captured count is known
      acc(1, IDX_CNT_LO, 8'h00, 8'h00);
      pin_lvl <= 1'b1;
      repeat (8) @(posedge clk);
      chk("irq", 8'h01, {7'h0, irq});
      acc(0, IDX_FLAGS, 8'h80, 8'h80);
      acc(0, IDX_CAP_HI, 8'hff, 8'hff);
      acc(0, IDX_CAP_LO, 8'hfd, 8'hff);
      acc(0, IDX_FLAGS, 8'h00, 8'h80);
      pin_lvl <= 1'b0;
      repeat (8) @(posedge clk);
      acc(0, IDX_FLAGS, 8'h00, 8'h80);
      acc(1, IDX_CONTROL, 8'h80, 8'h00);
      pin_lvl <= 1'b1;
      repeat (8) @(posedge clk);
      acc(0, IDX_FLAGS, 8'h00, 8'h80);
      pin_lvl <= 1'b0;
      repeat (8) @(posedge clk);
      acc(0, IDX_FLAGS, 8'h80, 8'h80);
      repeat (4) @(posedge clk);
      chk("notes left", 8'h00, exp_q.size());
      print_verdict();
   end
endmodule : tb_timer_capture_compare_unit

// File: test/tcc_pin_model.sv
/*
 * Model of the capture signal source outside the timer.
 * Assumes the bench asks for a level; the pin follows one clock later.
 */
`timescale 1ns/1ps
module tcc_pin_model (
   // clock and request
   input wire logic clk_i,
   input wire logic level_i,
   // pin
   output logic pin_o
);
   initial pin_o = 1'b0;
   // source changes only just after a clock edge
   always @(posedge clk_i) begin
      pin_o <= level_i;
   end
endmodule : tcc_pin_model
